// ==== i2c_device_end.sv ====
// Slave end of the two-wire register port of the sensor.
// Assumes a register file outside answers reads in the same cycle.
//
// Summary of operation
// RULE_01 - SDA sampled high SCL, changed low SCL.
// RULE_02 - Master opens with SDA fall, SCL high.
// RULE_03 - Repeated start behaves as ordinary start.
// RULE_04 - Master closes with SDA rise, SCL high.
// RULE_05 - Bus busy from start until stop.
// RULE_06 - Whole bytes, MSB first, each acknowledged.
// RULE_07 - Master makes every SCL pulse.
// RULE_08 - No clock stretching; work done in ack.
// RULE_09 - Transmitter releases, receiver pulls SDA low.
// RULE_10 - NACK is SDA high through ack.
// RULE_11 - After NACK master sends stop or restart.
// RULE_12 - Write: address, register, data, each acked.
// RULE_13 - Further write bytes go to next address.
// RULE_14 - Read: set address, restart, send data.
// RULE_15 - Master acks to continue, nacks last.
// RULE_16 - No slots enabled: plain increment, wraps.
// RULE_17 - Ch0 slot0 only: 63h wraps to 61h.
// RULE_18 - Ch0 slot1: 65h wraps to 61h.
// RULE_19 - Ch1 slot0: jump 65h-72h, 73h wraps.
// RULE_20 - Ch1 slot1: jump 65h-72h, 75h wraps.
// RULE_21 - Mismatched address: stay silent until start.
// RULE_22 - Wrap only for reads; writes plain.
//
// Local design decision: register access over a plain strobe port (reg_read, reg_write).
`timescale 1ns/1ps
module i2c_device_end
	import i2c_port_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	i2c_link_if.device      link,
	input  wire logic [6:0] slave_addr,
	input  wire logic [1:0] chan0_source_slot_enable,
	input  wire logic [1:0] chan1_source_slot_enable,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_write,
	output logic            reg_read,
	output logic            bus_busy
);
	typedef enum {
		st_idle,
		st_addr,
		st_regaddr,
		st_wdata,
		st_rdata,
		st_ignore
	} phase_e;

	logic       scl;
	logic       scl_rise;
	logic       scl_fall;
	logic       sda;
	logic       sda_rise;
	logic       sda_fall;
	phase_e     phase;
	logic [3:0] bit_cnt;
	logic [7:0] shifter;
	logic [7:0] tx_byte;
	logic       in_ack;
	logic       ack_drive;
	logic       master_nack;
	logic       start_seen;
	logic       stop_seen;
	logic       byte_done;
	logic [7:0] next_addr;
	logic       hold_ptr;

	line_sampler scl_sampler (
		.clock   (clock),
		.rst     (rst),
		.line_in (link.scl),
		.level   (scl),
		.rise    (scl_rise),
		.fall    (scl_fall)
	);

	line_sampler sda_sampler (
		.clock   (clock),
		.rst     (rst),
		.line_in (link.sda),
		.level   (sda),
		.rise    (sda_rise),
		.fall    (sda_fall)
	);

	// ==========================================================
	// Bus conditions.
	assign start_seen = scl & sda_fall; // see RULE_02, see RULE_03
	assign stop_seen  = scl & sda_rise; // see RULE_04
	assign byte_done  = scl_rise & (bit_cnt == 4'd7) & ~in_ack;

	always_ff @(posedge clock) begin
		if (rst) begin
			bus_busy <= 1'b0;
		end else if (start_seen) begin
			bus_busy <= 1'b1; // see RULE_05
		end else if (stop_seen) begin
			bus_busy <= 1'b0;
		end
	end

	// ==========================================================
	// Pointer advance with sensor-data wrap on reads.
	always_comb begin
		next_addr = 8'(reg_addr + 8'h01); // see RULE_16, see RULE_22
		if (phase == st_rdata) begin
			if (chan1_source_slot_enable[1]) begin
				if (reg_addr == chan0_slot1_sample_high_addr) begin
					next_addr = chan1_slot0_sample_low_addr; // see RULE_20
				end else if (reg_addr == chan1_slot1_sample_high_addr) begin
					next_addr = status_mirror_addr;
				end
			end else if (chan1_source_slot_enable[0]) begin
				if (reg_addr == chan0_slot1_sample_high_addr) begin
					next_addr = chan1_slot0_sample_low_addr; // see RULE_19
				end else if (reg_addr == chan1_slot0_sample_high_addr) begin
					next_addr = status_mirror_addr;
				end
			end else if (chan0_source_slot_enable[1]) begin
				if (reg_addr == chan0_slot1_sample_high_addr) begin
					next_addr = status_mirror_addr; // see RULE_18
				end
			end else if (chan0_source_slot_enable[0]) begin
				if (reg_addr == chan0_slot0_sample_high_addr) begin
					next_addr = status_mirror_addr; // see RULE_17
				end
			end
		end
	end

	// ==========================================================
	// Bit counter, shifter and phase sequencing.
	always_ff @(posedge clock) begin
		if (rst) begin
			phase       <= st_idle;
			bit_cnt     <= 4'd0;
			shifter     <= 8'h00;
			in_ack      <= 1'b0;
			ack_drive   <= 1'b0;
			master_nack <= 1'b0;
			reg_addr    <= 8'h00;
			reg_wdata   <= 8'h00;
			reg_write   <= 1'b0;
			reg_read    <= 1'b0;
			tx_byte     <= 8'h00;
			hold_ptr    <= 1'b0;
		end else begin
			reg_write <= 1'b0;
			reg_read  <= 1'b0;
			if (start_seen) begin
				phase   <= st_addr; // see RULE_03
				bit_cnt <= 4'd0;
				in_ack  <= 1'b0;
				ack_drive <= 1'b0;
				hold_ptr  <= 1'b0;
			end else if (stop_seen) begin
				phase     <= st_idle;
				ack_drive <= 1'b0;
			end else if (phase != st_idle && phase != st_ignore) begin
				if (byte_done) begin
					shifter <= {shifter[6:0], sda}; // see RULE_06
					in_ack  <= 1'b1;
					unique case (phase)
						st_addr: begin
							ack_drive <= (shifter[6:0] == slave_addr); // see RULE_21
							if (shifter[6:0] != slave_addr) begin
								phase <= st_ignore;
							end else if (sda) begin
								phase    <= st_rdata; // see RULE_14
								tx_byte  <= reg_rdata;
								reg_read <= 1'b1;
								hold_ptr <= 1'b1;
							end else begin
								phase <= st_regaddr;
							end
						end
						st_regaddr: begin
							ack_drive <= 1'b1; // see RULE_12
							reg_addr  <= {shifter[6:0], sda};
							phase     <= st_wdata;
							hold_ptr  <= 1'b1;
						end
						st_wdata: begin
							ack_drive <= 1'b1;
							reg_wdata <= {shifter[6:0], sda};
							reg_write <= 1'b1; // see RULE_13
						end
						st_rdata: ack_drive <= 1'b0; // see RULE_09
						default: ack_drive <= 1'b0;
					endcase
				end else if (scl_rise & ~in_ack) begin
					shifter <= {shifter[6:0], sda}; // see RULE_01
					bit_cnt <= 4'(bit_cnt + 4'd1);
				end else if (scl_rise & in_ack) begin
					master_nack <= sda; // see RULE_15
				end else if (scl_fall & in_ack & (bit_cnt == 4'd7)) begin
					bit_cnt <= 4'd8;
				end else if (scl_fall & in_ack & (bit_cnt == 4'd8)) begin
					in_ack    <= 1'b0;
					bit_cnt   <= 4'd0;
					ack_drive <= 1'b0;
					hold_ptr  <= 1'b0;
					// The byte right after an address byte keeps the pointer.
					if (phase == st_wdata && !hold_ptr) begin
						reg_addr <= next_addr;
					end
					if (phase == st_rdata && !hold_ptr) begin
						if (master_nack) begin
							phase <= st_ignore; // see RULE_11
						end else begin
							reg_addr <= next_addr; // see RULE_15
							reg_read <= 1'b1;
						end
					end
				end else if (scl_fall & ~in_ack & (bit_cnt != 4'd0)) begin
					tx_byte <= {tx_byte[6:0], 1'b0};
				end
				if (reg_read & (phase == st_rdata)) begin
					tx_byte <= reg_rdata;
				end
			end
		end
	end

	// ==========================================================
	// SDA drive, changed only around SCL low phases.
	always_ff @(posedge clock) begin
		if (rst) begin
			link.sda_dev_oe <= 1'b0;
		end else if (phase == st_idle || phase == st_ignore) begin
			link.sda_dev_oe <= 1'b0; // see RULE_10, see RULE_21
		end else if (~scl) begin
			if (in_ack) begin
				link.sda_dev_oe <= ack_drive & (bit_cnt == 4'd8); // see RULE_09
			end else if (phase == st_rdata) begin
				link.sda_dev_oe <= ~tx_byte[7]; // see RULE_01, see RULE_08
			end else begin
				link.sda_dev_oe <= 1'b0;
			end
		end
	end
endmodule : i2c_device_end

// ==== i2c_port_pkg.sv ====
// Constants shared by both ends of the two-wire register port.
// Assumes a 125 MHz system clock on each end.
package i2c_port_pkg;

	// ==========================================================
	// Register map and wrap points
	localparam logic [7:0] status_mirror_addr           = 8'h61;
	localparam logic [7:0] chan0_slot0_sample_high_addr = 8'h63;
	localparam logic [7:0] chan0_slot1_sample_high_addr = 8'h65;
	localparam logic [7:0] chan1_slot0_sample_low_addr  = 8'h72;
	localparam logic [7:0] chan1_slot0_sample_high_addr = 8'h73;
	localparam logic [7:0] chan1_slot1_sample_high_addr = 8'h75;

	// ==========================================================
	// Defaults and timing
	localparam logic [6:0] default_slave_addr  = 7'h2A;
	localparam int         clock_period_ns     = 8;
	localparam int         scl_half_ns         = 160;
	localparam int         scl_half_cycles     = scl_half_ns / clock_period_ns;
	localparam logic [9:0] scl_half_count      = 10'(scl_half_cycles - 1);

	// ==========================================================
	// Controller APB registers, word offsets
	localparam logic [7:0] ctrl_reg_off   = 8'h00;
	localparam logic [7:0] status_reg_off = 8'h04;
	localparam logic [7:0] txdata_reg_off = 8'h08;
	localparam logic [7:0] rxdata_reg_off = 8'h0C;

	// Command bit positions in the control register.
	localparam int cmd_start_bit = 0;
	localparam int cmd_write_bit = 1;
	localparam int cmd_read_bit  = 2;
	localparam int cmd_stop_bit  = 3;
	localparam int cmd_nack_bit  = 4;

	typedef enum logic [1:0] {
		cond_none,
		cond_start,
		cond_stop
	} cond_e;

endpackage : i2c_port_pkg

// ==== i2c_link_if.sv ====
// Two-wire link between the controller end and the device end.
// Assumes open-drain wires with pull-ups; the wire is low when any end drives.
`timescale 1ns/1ps
interface i2c_link_if;
	logic scl_oe;
	logic sda_ctrl_oe;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// ==========================================================
	// Wired-AND resolution of the open-drain lines.
	assign scl = ~scl_oe;
	assign sda = ~(sda_ctrl_oe | sda_dev_oe);

	modport controller (output scl_oe, output sda_ctrl_oe,
		input scl, input sda);
	modport device (output sda_dev_oe, input scl, input sda);
endinterface : i2c_link_if

// ==== line_sampler.sv ====
// Two-flop synchroniser for one line with edge detection.
// Assumes the line is asynchronous to clock.
`timescale 1ns/1ps
module line_sampler (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic line_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta;
	logic sync;
	logic prev;

	// ==========================================================
	// Synchroniser and edge detect.
	always_ff @(posedge clock) begin
		if (rst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= line_in;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;
endmodule : line_sampler

// ==== i2c_controller_end.sv ====
// Master end of the two-wire link, commanded over APB.
// Assumes software issues one command at a time and polls busy.
`timescale 1ns/1ps
module i2c_controller_end
	import i2c_port_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	i2c_link_if.controller   link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum {
		op_idle,
		op_start,
		op_bits,
		op_stop
	} op_e;

	op_e        op;
	logic [9:0] tick;
	logic [1:0] quarter;
	logic [3:0] bit_idx;
	logic [8:0] tx_word;
	logic [8:0] rx_word;
	logic [7:0] txdata;
	logic [7:0] rxdata;
	logic       got_nack;
	logic       nack_out;
	logic       scl_in;
	logic       sda_in;
	logic       wr_ctrl;
	logic       busy;

	line_sampler sda_sampler (
		.clock   (clock),
		.rst     (rst),
		.line_in (link.sda),
		.level   (sda_in),
		.rise    (),
		.fall    ()
	);

	line_sampler scl_sampler (
		.clock   (clock),
		.rst     (rst),
		.line_in (link.scl),
		.level   (scl_in),
		.rise    (),
		.fall    ()
	);

	// ==========================================================
	// APB slave, zero wait states.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(paddr == ctrl_reg_off ||
		paddr == status_reg_off || paddr == txdata_reg_off ||
		paddr == rxdata_reg_off);
	assign wr_ctrl = psel & penable & pwrite & (paddr == ctrl_reg_off);
	assign busy    = (op != op_idle);

	always_ff @(posedge clock) begin
		if (rst) begin
			txdata <= 8'h00;
		end else if (psel & penable & pwrite & (paddr == txdata_reg_off)) begin
			txdata <= pwdata[7:0];
		end
	end

	always_comb begin
		unique case (paddr)
			status_reg_off: prdata = {30'd0, got_nack, busy};
			txdata_reg_off: prdata = {24'd0, txdata};
			rxdata_reg_off: prdata = {24'd0, rxdata};
			default:        prdata = 32'd0;
		endcase
	end

	// ==========================================================
	// Bit engine: four quarters per SCL period.
	always_ff @(posedge clock) begin
		if (rst) begin
			op          <= op_idle;
			tick        <= 10'd0;
			quarter     <= 2'd0;
			bit_idx     <= 4'd0;
			tx_word     <= 9'h1FF;
			rx_word     <= 9'h000;
			rxdata      <= 8'h00;
			got_nack    <= 1'b0;
			nack_out    <= 1'b0;
			link.scl_oe      <= 1'b0;
			link.sda_ctrl_oe <= 1'b0;
		end else if (op == op_idle) begin
			tick    <= 10'd0;
			quarter <= 2'd0;
			if (wr_ctrl & pwdata[cmd_start_bit]) begin
				op <= op_start; // see RULE_02, see RULE_03
			end else if (wr_ctrl & pwdata[cmd_stop_bit]) begin
				op <= op_stop; // see RULE_04, see RULE_11
			end else if (wr_ctrl & (pwdata[cmd_write_bit] | pwdata[cmd_read_bit])) begin
				op       <= op_bits;
				bit_idx  <= 4'd0;
				nack_out <= pwdata[cmd_nack_bit];
				tx_word  <= pwdata[cmd_write_bit] ? {txdata, 1'b1} :
					{8'hFF, pwdata[cmd_nack_bit]}; // see RULE_15
			end
		end else if (tick != scl_half_count) begin
			tick <= 10'(tick + 10'd1);
		end else begin
			tick    <= 10'd0;
			quarter <= 2'(quarter + 2'd1);
			unique case (op)
				op_start: begin
					if (quarter == 2'd0) begin
						link.sda_ctrl_oe <= 1'b0;
					end else if (quarter == 2'd1) begin
						link.scl_oe <= 1'b0;
					end else if (quarter == 2'd2) begin
						link.sda_ctrl_oe <= 1'b1;
					end else begin
						link.scl_oe <= 1'b1;
						op <= op_idle;
					end
				end
				op_stop: begin
					if (quarter == 2'd0) begin
						link.sda_ctrl_oe <= 1'b1;
					end else if (quarter == 2'd1) begin
						link.scl_oe <= 1'b0;
					end else if (quarter == 2'd2) begin
						link.sda_ctrl_oe <= 1'b0;
						op <= op_idle;
					end
				end
				op_bits: begin
					if (quarter == 2'd0) begin
						link.sda_ctrl_oe <= ~tx_word[8]; // see RULE_01, see RULE_09
					end else if (quarter == 2'd1) begin
						link.scl_oe <= 1'b0; // see RULE_07
					end else if (quarter == 2'd2) begin
						rx_word <= {rx_word[7:0], sda_in & scl_in};
					end else begin
						link.scl_oe <= 1'b1;
						tx_word <= {tx_word[7:0], 1'b1}; // see RULE_06
						bit_idx <= 4'(bit_idx + 4'd1);
						if (bit_idx == 4'd8) begin
							op       <= op_idle;
							got_nack <= rx_word[0]; // see RULE_10
							rxdata   <= rx_word[8:1];
						end
					end
				end
				default: op <= op_idle;
			endcase
		end
	end
endmodule : i2c_controller_end

// ==== i2c_link_properties.sv ====
// Concurrent checks on the two-wire link between both ends.
// Assumes it sits beside the link interface, on the system clock.
`timescale 1ns/1ps
module i2c_link_properties
	import i2c_port_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_oe,
	input wire logic sda_ctrl_oe,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	// ==========================================================
	// Line history and bus state.
	logic scl_d;
	logic sda_d;
	logic busy;
	wire  start = scl && scl_d && sda_d && !sda;
	wire  stop  = scl && scl_d && !sda_d && sda;
	always_ff @(posedge clock) begin
		scl_d <= scl;
		sda_d <= sda;
	end
	always_ff @(posedge clock) begin
		if (rst || stop) begin
			busy <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
		end
	end
	// ==========================================================
	// Properties.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_dev_edge_low;
		$changed(sda_dev_oe) |-> !scl && !scl_d;
	endproperty
	a_dev_edge_low: assert property (p_dev_edge_low)
		else $error("device data moved while clock high");
	property p_start_hold;
		start |-> (scl && !sda_dev_oe) [*8];
	endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("start not held or device drove");
	property p_stop_free;
		stop |-> (scl && sda) [*8];
	endproperty
	a_stop_free: assert property (p_stop_free)
		else $error("bus not left free after stop");
	property p_dev_in_frame;
		sda_dev_oe |-> busy;
	endproperty
	a_dev_in_frame: assert property (p_dev_in_frame)
		else $error("device drove data outside a frame");
	property p_pulse_high;
		$rose(scl) |-> scl [*8];
	endproperty
	a_pulse_high: assert property (p_pulse_high)
		else $error("clock pulse too short");
	property p_dev_bounded;
		$rose(sda_dev_oe) |-> ##[1:1000] scl;
	endproperty
	a_dev_bounded: assert property (p_dev_bounded)
		else $error("device drive not followed by clock pulse");
	property p_ack_release;
		scl && sda_dev_oe |-> !sda_ctrl_oe;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("both ends drove data in one pulse");
	property p_ack_hold;
		$rose(scl) && sda_dev_oe |-> sda_dev_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("device dropped data in high phase");
	c_start: cover property (start);
	c_stop: cover property (stop);
	c_dev_ack: cover property ($rose(scl) && sda_dev_oe);
endmodule : i2c_link_properties

// ==== i2c_slave_register_port_test.sv ====
// Self-checking bench: controller end and device end joined by the link.
// Assumes a register file modelled here behind the device end.
`timescale 1ns/1ps
module i2c_slave_register_port_test
	import i2c_port_pkg::*;
;
	logic        clock, rst, psel, penable, pwrite;
	logic [7:0]  paddr, reg_addr, reg_wdata, reg_rdata;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, reg_write, reg_read, bus_busy;
	logic        err;
	logic [1:0]  en0, en1;
	logic [8:0]  wire_bits;
	logic [7:0]  mem [256];
	logic [7:0]  wlog [$];
	int          n_errors, tests_run;
	i2c_link_if i2c_link_if_inst ();
	i2c_controller_end i2c_controller_end_inst (.clock(clock), .rst(rst),
		.link(i2c_link_if_inst.controller), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	i2c_device_end i2c_device_end_inst (.clock(clock), .rst(rst),
		.link(i2c_link_if_inst.device), .slave_addr(default_slave_addr),
		.chan0_source_slot_enable(en0), .chan1_source_slot_enable(en1),
		.reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .bus_busy(bus_busy));
	i2c_link_properties i2c_link_properties_inst (.clock(clock),
		.rst(rst), .scl_oe(i2c_link_if_inst.scl_oe),
		.sda_ctrl_oe(i2c_link_if_inst.sda_ctrl_oe),
		.sda_dev_oe(i2c_link_if_inst.sda_dev_oe),
		.scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda));
	// ==========================================================
	// Register file and wire monitor.
	assign reg_rdata = mem[reg_addr];
	always @(posedge clock) begin
		if (reg_write === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
			wlog.push_back(reg_addr);
		end
	end
	always @(posedge i2c_link_if_inst.scl) begin
		wire_bits <= {wire_bits[7:0], i2c_link_if_inst.sda};
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// ==========================================================
	// Tasks.
	function automatic logic [7:0] ev(input logic [7:0] a);
		return (a == 8'hFF) ? 8'h96 : (a == 8'h00) ? 8'h69 : a ^ 8'hC3;
	endfunction : ev
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, ctrl_reg_off, {24'h0, c}, rd);
		do apb(1'b0, status_reg_off, 32'h0, rd);
		while (rd[0] !== 1'b0);
	endtask : cmd
	task automatic put(input logic [7:0] b, input logic nack);
		apb(1'b1, txdata_reg_off, {24'h0, b}, rd);
		cmd(8'h02);
		chk("ack", {31'h0, nack}, {31'h0, rd[1]});
	endtask : put
	task automatic open(input logic [7:0] r);
		cmd(8'h01);
		put({default_slave_addr, 1'b0}, 1'b0);
		put(r, 1'b0);
	endtask : open
	task automatic rseq(input logic [1:0] e1, input logic [1:0] e0,
		input logic [7:0] a [$]);
		en1 <= e1;
		en0 <= e0;
		open(a[0]);
		cmd(8'h01);
		put({default_slave_addr, 1'b1}, 1'b0);
		for (int i = 0; i < a.size(); i++) begin
			cmd((i == a.size() - 1) ? 8'h14 : 8'h04);
			apb(1'b0, rxdata_reg_off, 32'h0, rd);
			chk("rx", {24'h0, ev(a[i])}, rd);
		end
		cmd(8'h08);
	endtask : rseq
	task automatic summarize;
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// ==========================================================
	// Tests.
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{en0, en1, n_errors, tests_run} = '0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		open(8'hFF);
		chk("busy", 32'h1, {31'h0, bus_busy});
		put(8'h96, 1'b0);
		chk("wire", {23'h0, 9'h12C}, {23'h0, wire_bits});
		put(8'h69, 1'b0);
		cmd(8'h08);
		repeat (4) @(posedge clock);
		chk("busy", 32'h0, {31'h0, bus_busy});
		chk("wcount", 32'h2, wlog.size());
		chk("waddr", 32'hFF, {24'h0, wlog[0]});
		chk("waddr", 32'h00, {24'h0, wlog[1]});
		apb(1'b0, 8'h10, 32'h0, rd);
		chk("pslverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		cmd(8'h01);
		put({7'h55, 1'b0}, 1'b1);
		cmd(8'h08);
		rseq(2'b00, 2'b00, '{8'hFF, 8'h00});
		rseq(2'b00, 2'b01, '{8'h63, 8'h61});
		rseq(2'b00, 2'b10, '{8'h65, 8'h61});
		rseq(2'b01, 2'b00, '{8'h65, 8'h72, 8'h73, 8'h61});
		rseq(2'b10, 2'b00, '{8'h65, 8'h72, 8'h73, 8'h74, 8'h75,
			8'h61});
		summarize();
	end
	initial begin
		repeat (80000) @(posedge clock);
		n_errors++;
		summarize();
	end
endmodule : i2c_slave_register_port_test
